// ---- design/smsl_limit_mem.sv ----
`timescale 1ns/1ps
`include "smsl_map.svh"
module smsl_limit_mem
    import smsl_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_addr_in,
    input wire smsl_speed_t wr_data_in,
    input wire logic [2:0] rd_a_addr_in,
    output smsl_speed_t rd_a_data_out,
    input wire logic [2:0] rd_b_addr_in,
    output smsl_speed_t rd_b_data_out
);
    // ****************************************
    // eight stored speed limits
    // ****************************************
    smsl_speed_t mem_reg [8];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < 8; i++) begin
                mem_reg[i] <= `SMSL_LIMIT_RST;
            end
            rd_a_data_out <= `SMSL_LIMIT_RST;
            rd_b_data_out <= `SMSL_LIMIT_RST;
        end else if (ce_in) begin
            if (wr_en_in) begin
                mem_reg[wr_addr_in] <= wr_data_in;
            end
            rd_a_data_out <= mem_reg[rd_a_addr_in];
            rd_b_data_out <= mem_reg[rd_b_addr_in];
        end
    end
endmodule : smsl_limit_mem

// ---- design/smsl_sync.sv ----
`timescale 1ns/1ps
module smsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    // ****************************************
    // three stage capture, agree filter
    // ****************************************
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_next;
    // s1 feeds only s2; a change counts once s2 and s3 agree
    assign level_next = (s2_reg & s3_reg) | (level_out & (s2_reg | s3_reg));

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_out <= '0;
            rise_out <= '0;
            fall_out <= '0;
        end else if (ce_in) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_out <= level_next;
            rise_out <= level_next & ~level_out;
            fall_out <= ~level_next & level_out;
        end
    end
endmodule : smsl_sync

// ---- design/smsl_top.sv ----
// Behaviour
// - torque mode limits speed to one of eight stored limits by three select pins
// - default assignment uses only low select pin, choosing limit 0 or 1
// - forward select alone gives CCW limit, reverse select alone gives CW
// - limiting flag rises in torque mode when motor speed reaches the selected limit
// - servo-on and both stroke-end permits can be forced on by configuration
// - configuration value 1 selects position/internal-speed change mode
// - in that mode, change pin off gives position, on gives speed
// - with position involved, a change pin edge counts only at zero speed
// - leaving position for speed control clears droop pulses
// - in speed/torque mode, pin off gives speed, on gives torque
// - speed/torque changes are taken at any time, no zero-speed need
// - both starts off on entering speed control decelerates to stop
// - in torque/position mode, pin off gives torque, on gives position
// - leaving position for torque control clears droop pulses
// - any alarm shuts the drive stage off at once so motor coasts
// - alarm clears on reset pin rise, set key press or power cycle
// - alarm stays while its cause is still present
// - overcurrent, overload 1 and overload 2 report distinct alarm codes
// - control supply recovery raises the undervoltage alarm code
// - after an alarm in position control command pulses are ignored
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "smsl_map.svh"
module smsl_top
    import smsl_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    input wire logic speed_select_lo_in,
    input wire logic speed_select_mid_in,
    input wire logic speed_select_hi_in,
    input wire logic fwd_select_in,
    input wire logic rev_select_in,
    input wire logic mode_change_input_in,
    input wire logic alarm_reset_input_in,
    input wire logic fwd_start_input_in,
    input wire logic rev_start_input_in,
    input wire logic servo_on_in,
    input wire logic fwd_stroke_end_ok_in,
    input wire logic rev_stroke_end_ok_in,
    input wire logic set_key_in,
    input wire logic signed [15:0] motor_speed_in,
    input wire logic zero_speed_flag_in,
    input wire logic overcurrent_in,
    input wire logic overload1_in,
    input wire logic overload2_in,
    input wire logic undervoltage_in,
    output logic speed_limiting_flag_out,
    output smsl_speed_t limit_value_out,
    output smsl_dir_e limit_dir_out,
    output smsl_ctl_e ctl_mode_out,
    output logic droop_clear_out,
    output logic decel_stop_out,
    output logic base_drive_en_out,
    output logic pulse_accept_out,
    output logic alarm_out,
    output logic [11:0] alarm_code_out,
    output logic servo_on_out,
    output logic fwd_stroke_end_ok_out,
    output logic rev_stroke_end_ok_out
);
    // ****************************************
    // helper functions
    // ****************************************
    function automatic smsl_speed_t speed_mag(input logic signed [15:0] s);
        speed_mag = s[15] ? smsl_speed_t'(-s) : smsl_speed_t'(s);
    endfunction : speed_mag

    function automatic logic limit_hit(input logic [7:0] a);
        limit_hit = (a[7:5] == `SMSL_LIMIT_BASE_HI) && (a[1:0] == 2'h0);
    endfunction : limit_hit

    function automatic smsl_ctl_e mode_of(input logic [2:0] m, input logic mode_change_input);
        unique case (m)
            `SMSL_CMODE_POS: mode_of = SMSL_CTL_POS;
            `SMSL_CMODE_POS_SPD: mode_of = mode_change_input ? SMSL_CTL_SPD : SMSL_CTL_POS;
            `SMSL_CMODE_SPD: mode_of = SMSL_CTL_SPD;
            `SMSL_CMODE_SPD_TRQ: mode_of = mode_change_input ? SMSL_CTL_TRQ : SMSL_CTL_SPD;
            `SMSL_CMODE_TRQ: mode_of = SMSL_CTL_TRQ;
            `SMSL_CMODE_TRQ_POS: mode_of = mode_change_input ? SMSL_CTL_POS : SMSL_CTL_TRQ;
            default: mode_of = SMSL_CTL_POS;
        endcase
    endfunction : mode_of

    function automatic logic [11:0] code_of(input logic oc, input logic ol1,
                                            input logic ol2);
        code_of = oc ? `SMSL_ALM_OVERCURRENT : (ol1 ? `SMSL_ALM_OVERLOAD1 :
                  (ol2 ? `SMSL_ALM_OVERLOAD2 : `SMSL_ALM_UNDERVOLT));
    endfunction : code_of

    // ****************************************
    // pin capture
    // ****************************************
    smsl_pins_s pins_raw;
    logic [`SMSL_PIN_COUNT-1:0] lvl_vec;
    logic [`SMSL_PIN_COUNT-1:0] rise_vec;
    logic [`SMSL_PIN_COUNT-1:0] fall_vec;
    smsl_pins_s pin_lvl;
    smsl_pins_s pin_rise;
    smsl_pins_s pin_fall;

    assign pins_raw = '{set_key: set_key_in, rev_stroke: rev_stroke_end_ok_in,
                        fwd_stroke: fwd_stroke_end_ok_in, servo_on: servo_on_in,
                        rev_start: rev_start_input_in, fwd_start: fwd_start_input_in,
                        alarm_reset: alarm_reset_input_in,
                        mode_change: mode_change_input_in,
                        rev_select: rev_select_in, fwd_select: fwd_select_in,
                        speed_hi: speed_select_hi_in, speed_mid: speed_select_mid_in,
                        speed_lo: speed_select_lo_in};
    assign pin_lvl = smsl_pins_s'(lvl_vec);
    assign pin_rise = smsl_pins_s'(rise_vec);
    assign pin_fall = smsl_pins_s'(fall_vec);

    smsl_sync #(
        .WIDTH(`SMSL_PIN_COUNT)
    ) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .async_in(pins_raw),
        .level_out(lvl_vec),
        .rise_out(rise_vec),
        .fall_out(fall_vec)
    );

    // ****************************************
    // register bus
    // ****************************************
    smsl_cfg_s cfg_reg;
    logic [31:0] rdata_reg;
    logic rd_mem_reg;
    logic limit_wr;
    logic [2:0] bus_idx;
    logic [31:0] rd_mux;
    smsl_speed_t mem_qa;
    smsl_speed_t mem_qb;
    logic [2:0] sel_idx_reg;
    logic [2:0] sel_idx_next;
    smsl_ctl_e mode_reg;
    smsl_alarm_e alarm_reg;
    logic [11:0] code_reg;

    assign bus_idx = bus_addr_in[`SMSL_LIMIT_IDX_MSB:`SMSL_LIMIT_IDX_LSB];
    assign limit_wr = bus_wr_in && limit_hit(bus_addr_in);
    assign rd_mux = (bus_addr_in == `SMSL_ADDR_CTRL) ? {25'h0, cfg_reg} :
                    (bus_addr_in == `SMSL_ADDR_STATUS) ?
                    {28'h0, speed_limiting_flag_out, alarm_reg, mode_reg} :
                    (bus_addr_in == `SMSL_ADDR_ALARM) ? {20'h0, code_reg} : 32'h0;
    // stored limits come out of the memory's own read register
    assign bus_rdata_out = rd_mem_reg ? {16'h0, mem_qb} : rdata_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cfg_reg <= `SMSL_CTRL_RST;
            rdata_reg <= 32'h0;
            rd_mem_reg <= 1'b0;
        end else if (ce_in) begin
            if (bus_wr_in && bus_addr_in == `SMSL_ADDR_CTRL) begin
                cfg_reg <= bus_wdata_in[6:0];
            end
            rdata_reg <= bus_rd_in ? rd_mux : 32'h0;
            rd_mem_reg <= bus_rd_in && limit_hit(bus_addr_in);
        end
    end

    smsl_limit_mem u_mem (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .wr_en_in(limit_wr),
        .wr_addr_in(bus_idx),
        .wr_data_in(bus_wdata_in[15:0]),
        .rd_a_addr_in(sel_idx_reg),
        .rd_a_data_out(mem_qa),
        .rd_b_addr_in(bus_idx),
        .rd_b_data_out(mem_qb)
    );

    // ****************************************
    // speed limit selection and flag
    // ****************************************
    smsl_dir_e dir_next;
    logic flag_next;

    // without full assignment the mid and high selects read as off
    assign sel_idx_next = cfg_reg.assign_all ?
                          {pin_lvl.speed_hi, pin_lvl.speed_mid, pin_lvl.speed_lo} :
                          {2'b00, pin_lvl.speed_lo};
    assign dir_next = (pin_lvl.fwd_select && !pin_lvl.rev_select) ? SMSL_DIR_CCW :
                      (!pin_lvl.fwd_select && pin_lvl.rev_select) ? SMSL_DIR_CW :
                      SMSL_DIR_NONE;
    // limit lags a select change by two cycles; harmless against a motor loop
    assign flag_next = (mode_reg == SMSL_CTL_TRQ) &&
                       (speed_mag(motor_speed_in) >= mem_qa);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sel_idx_reg <= 3'h0;
            limit_value_out <= `SMSL_LIMIT_RST;
            limit_dir_out <= SMSL_DIR_NONE;
            speed_limiting_flag_out <= 1'b0;
        end else if (ce_in) begin
            sel_idx_reg <= sel_idx_next;
            limit_value_out <= mem_qa;
            limit_dir_out <= dir_next;
            speed_limiting_flag_out <= flag_next;
        end
    end

    // ****************************************
    // control mode change
    // ****************************************
    logic lop_eff_reg;
    logic lop_eff_next;
    logic has_pos;
    logic lop_edge;
    smsl_ctl_e mode_next;
    logic droop_next;
    logic decel_next;

    assign has_pos = (cfg_reg.mode == `SMSL_CMODE_POS_SPD) ||
                     (cfg_reg.mode == `SMSL_CMODE_TRQ_POS);
    assign lop_edge = pin_rise.mode_change || pin_fall.mode_change;
    // an edge missed away from zero speed stays missed until the next edge
    assign lop_eff_next = (cfg_reg.mode == `SMSL_CMODE_SPD_TRQ) ? pin_lvl.mode_change :
                          (has_pos && lop_edge && zero_speed_flag_in) ?
                          pin_lvl.mode_change : lop_eff_reg;
    assign mode_next = mode_of(cfg_reg.mode, lop_eff_next);
    assign droop_next = (mode_reg == SMSL_CTL_POS) && (mode_next != SMSL_CTL_POS);
    assign decel_next = (mode_next == SMSL_CTL_SPD) && !pin_lvl.fwd_start &&
                        !pin_lvl.rev_start && ((mode_reg != SMSL_CTL_SPD) || decel_stop_out);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            lop_eff_reg <= 1'b0;
            mode_reg <= SMSL_CTL_POS;
            ctl_mode_out <= SMSL_CTL_POS;
            droop_clear_out <= 1'b0;
            decel_stop_out <= 1'b0;
        end else if (ce_in) begin
            lop_eff_reg <= lop_eff_next;
            mode_reg <= mode_next;
            ctl_mode_out <= mode_next;
            droop_clear_out <= droop_next;
            decel_stop_out <= decel_next;
        end
    end

    // ****************************************
    // alarm handling
    // ****************************************
    logic uv_d_reg;
    logic uv_event;
    logic trip_evt;
    logic cause_now;
    logic clear_req;
    smsl_alarm_e alarm_next;
    logic [11:0] code_next;

    assign uv_event = uv_d_reg && !undervoltage_in;
    assign trip_evt = overcurrent_in || overload1_in || overload2_in || uv_event;
    assign cause_now = overcurrent_in || overload1_in || overload2_in || undervoltage_in;
    assign clear_req = pin_rise.alarm_reset || pin_rise.set_key;
    // a fresh trip in the clear cycle wins over the clear
    assign alarm_next = (alarm_reg == SMSL_ALM_RUN) ?
                        (trip_evt ? SMSL_ALM_TRIP : SMSL_ALM_RUN) :
                        ((clear_req && !cause_now && !trip_evt) ?
                        SMSL_ALM_RUN : SMSL_ALM_TRIP);
    assign code_next = (alarm_reg == SMSL_ALM_RUN && trip_evt) ?
                       code_of(overcurrent_in, overload1_in, overload2_in) :
                       (alarm_next == SMSL_ALM_RUN) ? `SMSL_ALM_NONE : code_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            uv_d_reg <= 1'b0;
            alarm_reg <= SMSL_ALM_RUN;
            code_reg <= `SMSL_ALM_NONE;
            alarm_out <= 1'b0;
            alarm_code_out <= `SMSL_ALM_NONE;
        end else if (ce_in) begin
            uv_d_reg <= undervoltage_in;
            alarm_reg <= alarm_next;
            code_reg <= code_next;
            alarm_out <= (alarm_next == SMSL_ALM_TRIP);
            alarm_code_out <= code_next;
        end
    end

    // ****************************************
    // drive enables
    // ****************************************
    logic son_eff;
    logic lsp_eff;
    logic lsn_eff;

    assign son_eff = cfg_reg.auto_on[0] || pin_lvl.servo_on;
    assign lsp_eff = cfg_reg.auto_on[1] || pin_lvl.fwd_stroke;
    assign lsn_eff = cfg_reg.auto_on[2] || pin_lvl.rev_stroke;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            servo_on_out <= 1'b0;
            fwd_stroke_end_ok_out <= 1'b0;
            rev_stroke_end_ok_out <= 1'b0;
            base_drive_en_out <= 1'b0;
            pulse_accept_out <= 1'b0;
        end else if (ce_in) begin
            servo_on_out <= son_eff;
            fwd_stroke_end_ok_out <= lsp_eff;
            rev_stroke_end_ok_out <= lsn_eff;
            base_drive_en_out <= son_eff && (alarm_next == SMSL_ALM_RUN);
            pulse_accept_out <= (mode_next == SMSL_CTL_POS) &&
                                (alarm_next == SMSL_ALM_RUN);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_clear_req;
        ce_in && alarm_reg == SMSL_ALM_TRIP && clear_req;
    endsequence

    sequence s_clean;
        !cause_now && !trip_evt;
    endsequence

    alarm_trip_a: assert property (ce_in && trip_evt |=> !base_drive_en_out && alarm_out)
        else $error("drive stayed on after alarm cause");
    alarm_hold_a: assert property (s_clear_req and cause_now |=> alarm_reg == SMSL_ALM_TRIP)
        else $error("alarm cleared with cause present");
    alarm_clear_a: assert property ((s_clear_req and s_clean) |=> !alarm_out)
        else $error("alarm not cleared by reset event");
    pulse_gate_a: assert property (alarm_out |-> !pulse_accept_out)
        else $error("pulses accepted during alarm");
    droop_pulse_a: assert property (droop_clear_out && $past(ce_in) |->
        $past(mode_reg) == SMSL_CTL_POS && mode_reg != SMSL_CTL_POS)
        else $error("droop clear without leaving position");
    zero_gate_a: assert property (ce_in && has_pos && lop_edge && !zero_speed_flag_in
        && !bus_wr_in |=> $stable(lop_eff_reg))
        else $error("mode change taken away from zero speed");
    limit_flag_a: assert property (ce_in && mode_reg == SMSL_CTL_TRQ &&
        speed_mag(motor_speed_in) >= mem_qa |=> speed_limiting_flag_out)
        else $error("limiting flag missing at limit");
    dir_ccw_a: assert property (ce_in && pin_lvl.fwd_select && !pin_lvl.rev_select
        |=> limit_dir_out == SMSL_DIR_CCW)
        else $error("limit direction not forward");
    default_sel_a: assert property (ce_in && !cfg_reg.assign_all |=>
        sel_idx_reg == {2'b00, $past(pin_lvl.speed_lo)})
        else $error("default selection uses upper selects");
    spd_trq_a: assert property (ce_in && cfg_reg.mode == `SMSL_CMODE_SPD_TRQ && !bus_wr_in
        && pin_lvl.mode_change |=> ctl_mode_out == SMSL_CTL_TRQ)
        else $error("torque mode not taken at once");
endmodule : smsl_top

// ---- pkg/smsl_map.svh ----
`ifndef SMSL_MAP_SVH
`define SMSL_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SMSL_ADDR_CTRL 8'h00
`define SMSL_ADDR_STATUS 8'h04
`define SMSL_ADDR_ALARM 8'h08
`define SMSL_LIMIT_BASE_HI 3'h1
`define SMSL_LIMIT_IDX_LSB 2
`define SMSL_LIMIT_IDX_MSB 4

// ****************************************
// control register fields
// ****************************************
`define SMSL_CTRL_MODE_LSB 0
`define SMSL_CTRL_MODE_MSB 2
`define SMSL_CTRL_AUTO_LSB 3
`define SMSL_CTRL_AUTO_MSB 5
`define SMSL_CTRL_ASSIGN_BIT 6
`define SMSL_CTRL_RST 7'h00

// ****************************************
// control mode selection codes
// ****************************************
`define SMSL_CMODE_POS 3'h0
`define SMSL_CMODE_POS_SPD 3'h1
`define SMSL_CMODE_SPD 3'h2
`define SMSL_CMODE_SPD_TRQ 3'h3
`define SMSL_CMODE_TRQ 3'h4
`define SMSL_CMODE_TRQ_POS 3'h5

// ****************************************
// reset values and alarm codes
// ****************************************
`define SMSL_LIMIT_RST 16'h0064
`define SMSL_ALM_NONE 12'h000
`define SMSL_ALM_OVERCURRENT 12'h320
`define SMSL_ALM_OVERLOAD1 12'h500
`define SMSL_ALM_OVERLOAD2 12'h510
`define SMSL_ALM_UNDERVOLT 12'h101
`define SMSL_PIN_COUNT 13

`endif

// ---- pkg/smsl_pkg.sv ----
package smsl_pkg;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SMSL_CTL_POS = 2'h0,
        SMSL_CTL_SPD = 2'h1,
        SMSL_CTL_TRQ = 2'h3
    } smsl_ctl_e;

    typedef enum logic {
        SMSL_ALM_RUN = 1'b0,
        SMSL_ALM_TRIP = 1'b1
    } smsl_alarm_e;

    typedef enum logic [1:0] {
        SMSL_DIR_NONE = 2'h0,
        SMSL_DIR_CCW = 2'h1,
        SMSL_DIR_CW = 2'h2
    } smsl_dir_e;

    typedef struct packed {
        logic set_key;
        logic rev_stroke;
        logic fwd_stroke;
        logic servo_on;
        logic rev_start;
        logic fwd_start;
        logic alarm_reset;
        logic mode_change;
        logic rev_select;
        logic fwd_select;
        logic speed_hi;
        logic speed_mid;
        logic speed_lo;
    } smsl_pins_s;

    typedef struct packed {
        logic assign_all;
        logic [2:0] auto_on;
        logic [2:0] mode;
    } smsl_cfg_s;

    typedef logic [15:0] smsl_speed_t;

endpackage : smsl_pkg

// ---- sim/smsl_host.sv ----
`timescale 1ns/1ps
module smsl_host
    import smsl_pkg::*;
(
    input wire logic clk_in,
    input wire smsl_pins_s want_in,
    input wire logic alarm_in,
    output smsl_pins_s pins_out
);
    // ****************************************
    // contact drivers
    // ****************************************
    // a tripped device never sees a start, so restart needs the host's say
    always_ff @(posedge clk_in) begin
        pins_out <= smsl_pins_s'(alarm_in ? (want_in & ~13'h0180) : want_in);
    end
endmodule : smsl_host

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench import smsl_pkg::*;;
    logic clk_in, reset_in, ce_in, bus_wr_in, bus_rd_in, zero_speed_flag_in, droop_seen;
    logic overcurrent_in, overload1_in, overload2_in, undervoltage_in, z;
    logic [7:0] bus_addr_in;
    logic [31:0] bus_wdata_in, bus_rdata_out, d;
    logic signed [15:0] motor_speed_in, s;
    logic speed_limiting_flag_out, droop_clear_out, decel_stop_out, base_drive_en_out;
    logic pulse_accept_out, alarm_out, servo_on_out, fwd_stroke_end_ok_out, rev_stroke_end_ok_out;
    logic [11:0] alarm_code_out;
    logic [11:0] codes [3] = '{12'h320, 12'h500, 12'h510};
    logic [3:0] f;
    smsl_speed_t limit_value_out;
    smsl_dir_e limit_dir_out;
    smsl_ctl_e ctl_mode_out;
    smsl_pins_s want, w, p;
    int mismatches, n_compared, cycles;

    smsl_top i_dut (.*, .speed_select_lo_in(p.speed_lo), .speed_select_mid_in(p.speed_mid),
        .speed_select_hi_in(p.speed_hi), .fwd_select_in(p.fwd_select),
        .rev_select_in(p.rev_select), .mode_change_input_in(p.mode_change),
        .alarm_reset_input_in(p.alarm_reset), .fwd_start_input_in(p.fwd_start),
        .rev_start_input_in(p.rev_start), .servo_on_in(p.servo_on),
        .fwd_stroke_end_ok_in(p.fwd_stroke), .rev_stroke_end_ok_in(p.rev_stroke),
        .set_key_in(p.set_key));
    smsl_host i_host (.clk_in(clk_in), .want_in(want), .alarm_in(alarm_out), .pins_out(p));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // the whole sequence is some 590 cycles, so this ceiling only cuts a hang
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    // ****************************************
    // access tasks
    // ****************************************
    function automatic smsl_speed_t lim(input int i);
        return 16'h0200 + 16'(i) * 16'h0040;
    endfunction : lim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= v;
        bus_wr_in <= wr;
        bus_rd_in <= ~wr;
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
        bus_rd_in <= 1'b0;
        #1 d = bus_rdata_out;
    endtask : bus

    // pins need up to eight edges to reach the outputs; twelve leaves margin
    task automatic put();
        @(posedge clk_in);
        want <= w;
        {undervoltage_in, overload2_in, overload1_in, overcurrent_in} <= f;
        zero_speed_flag_in <= z;
        motor_speed_in <= s;
        droop_seen = 1'b0;
        // sample just after each edge, once the outputs have settled
        repeat (12) begin
            @(posedge clk_in);
            #1 droop_seen = droop_seen | droop_clear_out;
        end
    endtask : put

    task automatic results();
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {bus_wr_in, bus_rd_in, bus_addr_in, bus_wdata_in, mismatches, n_compared, cycles} = '0;
        {overcurrent_in, overload1_in, overload2_in, undervoltage_in, zero_speed_flag_in} = '0;
        {want, w, f, z, s, motor_speed_in} = '0;
        ce_in = 1'b1;
        reset_in = 1'b1;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        check(limit_value_out, 16'h0064);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'h20 + 8'(4 * i), 32'(lim(i)));
        bus(1'b0, 8'hF0, 32'h0);
        check(d, 32'h0);
        bus(1'b0, 8'h3C, 32'h0);
        check(d, 32'(lim(7)));
        bus(1'b1, 8'h00, 32'h04);
        w.speed_hi = 1'b1;
        for (int i = 0; i < 2; i++) begin
            w.speed_lo = i[0];
            put();
            check(limit_value_out, lim(i));
        end
        bus(1'b1, 8'h00, 32'h44);
        bus(1'b0, 8'h00, 32'h0);
        check(d, 32'h44);
        for (int i = 0; i < 8; i++) begin
            {w.speed_hi, w.speed_mid, w.speed_lo} = i[2:0];
            put();
            check(limit_value_out, lim(i));
        end
        // clock enable low: nothing may move, not even at the limit
        ce_in <= 1'b0;
        s = -lim(7);
        put();
        check(speed_limiting_flag_out, 1'b0);
        ce_in <= 1'b1;
        put();
        check(speed_limiting_flag_out, 1'b1);
        s = lim(7) - 16'h0001;
        put();
        check(speed_limiting_flag_out, 1'b0);
        for (int i = 1; i < 3; i++) begin
            {w.fwd_select, w.rev_select} = 2'(3 - i);
            put();
            check(limit_dir_out, i);
        end
        bus(1'b1, 8'h00, 32'h7B);
        for (int i = 1; i >= 0; i--) begin
            w.mode_change = i[0];
            put();
            check(ctl_mode_out, i ? SMSL_CTL_TRQ : SMSL_CTL_SPD);
        end
        check({servo_on_out, fwd_stroke_end_ok_out, rev_stroke_end_ok_out}, 3'h7);
        bus(1'b1, 8'h00, 32'h79);
        z = 1'b1;
        w.mode_change = 1'b1;
        put();
        check(ctl_mode_out, SMSL_CTL_SPD);
        check({droop_seen, decel_stop_out}, 2'h3);
        z = 1'b0;
        w.mode_change = 1'b0;
        put();
        check(ctl_mode_out, SMSL_CTL_SPD);
        z = 1'b1;
        put();
        check(ctl_mode_out, SMSL_CTL_SPD);
        bus(1'b1, 8'h00, 32'h7D);
        for (int i = 1; i >= 0; i--) begin
            w.mode_change = i[0];
            put();
            check(ctl_mode_out, i ? SMSL_CTL_POS : SMSL_CTL_TRQ);
        end
        check(droop_seen, 1'b1);
        w.mode_change = 1'b1;
        put();
        check(pulse_accept_out, 1'b1);
        for (int i = 0; i < 3; i++) begin
            f = 4'(1 << i);
            put();
            check({alarm_out, base_drive_en_out, pulse_accept_out}, 3'h4);
            check(alarm_code_out, codes[i]);
            bus(1'b0, 8'h04, 32'h0);
            check(d, 32'h4);
            bus(1'b0, 8'h08, 32'h0);
            check(d, 32'(codes[i]));
            w.alarm_reset = 1'b1;
            put();
            check(alarm_out, 1'b1);
            {f, w.alarm_reset} = '0;
            put();
            w.alarm_reset = 1'b1;
            put();
            check({alarm_out, base_drive_en_out, pulse_accept_out}, 3'h3);
            w.alarm_reset = 1'b0;
        end
        f = 4'h8;
        put();
        f = 4'h0;
        put();
        check(alarm_code_out, 12'h101);
        w.set_key = 1'b1;
        put();
        check(alarm_out, 1'b0);
        f = 4'h1;
        put();
        f = 4'h0;
        put();
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        put();
        check(alarm_out, 1'b0);
        results();
    end
endmodule : testbench
